// ==== hw/dual_wiper_serial_loader.sv ====
// Serial wiper loader: link-side shift chain and system-side update control
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Each wiper uses an 8-bit code selecting one of 256 taps.
// - Serial clock and data are ignored while port select is low.
// - While selected, data is captured on each serial clock rising edge.
// - Chain position 0 holds the stacked output selector.
// - Positions 1 to 8 hold wiper one code, MSB in position 1.
// - Positions 9 to 16 hold wiper zero code, MSB in position 9.
// - Falling port select copies chain into latches; only then wipers move.
// - At power-up both wipers sit at mid-scale, 8'h80.
// - Stacked output shows wiper zero for selector 0, wiper one for 1.
// - Cascade output always carries the last chain stage.
// - Selector bit leaves the cascade output first in a transaction.
// - Each rising edge loads data into first stage, shifts next bit out.
// - A full circular shift restores the chain, so wipers reload unchanged.

module dual_wiper_serial_loader (
    // System clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // Three-wire serial port, timed by the controller's serial clock
    input  wire logic                     sclk,
    input  wire logic                     port_select,
    input  wire logic                     serial_data_in,
    // Cascade port, serial clock domain
    output logic                          chain_data_out,
    // Wiper codes toward the resistor arrays
    output wiper_loader_pkg::code_t       wiper_terminal_zero,
    output wiper_loader_pkg::code_t       wiper_terminal_one,
    output wiper_loader_pkg::code_t       stacked_wiper_out,
    output logic                          stack_select,
    // Status, system clock domain
    output logic                          wiper_update,
    output logic                          frame_short,
    output logic                          port_active
);
    import wiper_loader_pkg::*;

    // Serial clock domain state
    typedef struct packed {
        chain_t chain;
        phase_t phase;
    } link_state_t;

    // System clock domain state
    typedef struct packed {
        logic   sel_prev;
        phase_t phase_mark;
        logic   short_flag;
    } core_state_t;

    link_state_t link_reg;
    link_state_t link_next;
    core_state_t core_reg;
    core_state_t core_next;
    logic        link_nrst;
    logic        sel_sync;
    logic        sel_fall;

    // Reset reaches the chain only while the serial clock runs
    bit_sync #(
        .STAGES   (SYNC_STAGES)
    ) u_link_rst_sync (
        .clk      (sclk),
        .async_in (nrst),
        .sync_out (link_nrst)
    );

    bit_sync #(
        .STAGES   (SYNC_STAGES)
    ) u_sel_sync (
        .clk      (clk),
        .async_in (port_select),
        .sync_out (sel_sync)
    );

    // Port select and data are launched against the serial clock, so they are
    // sampled here directly as same-domain signals.
    always_comb begin
        link_next = link_reg;
        if (!link_nrst) begin
            link_next.chain = CHAIN_RESET;
            link_next.phase = PHASE_ZERO;
        end else if (port_select) begin
            // Shift toward the cascade end; feedback makes this circular
            link_next.chain = {serial_data_in, link_reg.chain[CHAIN_LEN-1:1]};
            link_next.phase = (link_reg.phase == PHASE_LAST) ? PHASE_ZERO
                                                             : link_reg.phase + PHASE_STEP;
        end
        // Otherwise hold: select low freezes the chain
    end

    always_ff @(posedge sclk) begin
        link_reg <= link_next;
    end

    // Selector sits at the cascade end, so it leaves first
    assign chain_data_out = link_reg.chain[SEL_POS];

    // Chain and phase are frozen once select is low, so the system side may
    // read them as quasi-static words after the synchronised fall.
    assign sel_fall = core_reg.sel_prev & ~sel_sync;

    always_comb begin
        core_next = core_reg;
        core_next.sel_prev = sel_sync;
        if (sel_fall) begin
            // Bit count modulo 17 must not move between two frame ends
            core_next.short_flag = (link_reg.phase != core_reg.phase_mark);
            core_next.phase_mark = link_reg.phase;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            core_reg <= '{sel_prev: 1'b0, phase_mark: PHASE_ZERO, short_flag: 1'b0};
        end else begin
            core_reg <= core_next;
        end
    end

    wiper_latch u_latch (
        .clk          (clk),
        .nrst         (nrst),
        .load         (sel_fall),
        .chain        (link_reg.chain),
        .wiper_zero   (wiper_terminal_zero),
        .wiper_one    (wiper_terminal_one),
        .stacked      (stacked_wiper_out),
        .stack_select (stack_select),
        .updated      (wiper_update)
    );

    assign frame_short = core_reg.short_flag;
    assign port_active = core_reg.sel_prev;

endmodule : dual_wiper_serial_loader

`default_nettype wire

// ==== hw/wiper_loader_pkg.sv ====
// Shared constants, types and code extraction for the serial wiper loader
package wiper_loader_pkg;

    // Chain layout: position 0 sits at the cascade end, position 16 at the data input
    localparam int unsigned CHAIN_LEN    = 17;
    localparam int unsigned WIPER_W      = 8;
    localparam int unsigned SEL_POS      = 0;
    localparam int unsigned POT1_MSB_POS = 1;
    localparam int unsigned POT0_MSB_POS = 9;
    localparam int unsigned PHASE_W      = $clog2(CHAIN_LEN);
    localparam int unsigned SYNC_STAGES  = 2;

    typedef logic [WIPER_W-1:0]   code_t;
    typedef logic [CHAIN_LEN-1:0] chain_t;
    typedef logic [PHASE_W-1:0]   phase_t;

    localparam code_t  WIPER_MIDSCALE = 8'h80;
    localparam logic   SEL_RESET      = 1'b0;
    // Both codes at mid-scale, selector clear
    localparam chain_t CHAIN_RESET    = 17'h00202;
    localparam phase_t PHASE_ZERO     = 5'h00;
    localparam phase_t PHASE_LAST     = 5'h10;
    localparam phase_t PHASE_STEP     = 5'h01;

    // Pull one code out of the chain, most significant bit at msb_pos
    function automatic code_t extract_code(chain_t chain, int unsigned msb_pos);
        code_t code;
        code = '0;
        for (int unsigned i = 0; i < WIPER_W; i++) begin
            code[WIPER_W-1-i] = chain[msb_pos+i];
        end
        return code;
    endfunction : extract_code

endpackage : wiper_loader_pkg

// ==== hw/bit_sync.sv ====
// Two-flop level synchroniser, no reset so it can carry a reset itself
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
    parameter int unsigned STAGES = wiper_loader_pkg::SYNC_STAGES
) (
    // Destination clock
    input  wire logic clk,
    // Level from another domain
    input  wire logic async_in,
    output logic      sync_out
);
    import wiper_loader_pkg::*;

    if (STAGES < 2) begin : g_bad_stages
        $error("bit_sync needs at least two stages");
    end

    typedef struct packed {
        logic [STAGES-1:0] stage;
    } sync_state_t;

    sync_state_t sync_reg;
    sync_state_t sync_next;

    always_comb begin
        sync_next = sync_reg;
        sync_next.stage = {sync_reg.stage[STAGES-2:0], async_in};
    end

    always_ff @(posedge clk) begin
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg.stage[STAGES-1];

endmodule : bit_sync

`default_nettype wire

// ==== hw/wiper_latch.sv ====
// Wiper and stacked-selector latches, loaded from the chain at end of frame
`timescale 1ns/1ps
`default_nettype none

module wiper_latch (
    // System clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // Load strobe and quasi-static chain image
    input  wire logic                     load,
    input  wire wiper_loader_pkg::chain_t chain,
    // Latched state
    output wiper_loader_pkg::code_t       wiper_zero,
    output wiper_loader_pkg::code_t       wiper_one,
    output wiper_loader_pkg::code_t       stacked,
    output logic                          stack_select,
    output logic                          updated
);
    import wiper_loader_pkg::*;

    typedef struct packed {
        code_t w0;
        code_t w1;
        code_t stacked;
        logic  sel;
        logic  upd;
    } latch_state_t;

    latch_state_t latch_reg;
    latch_state_t latch_next;

    always_comb begin
        latch_next = latch_reg;
        latch_next.upd = 1'b0;
        if (load) begin
            latch_next.w0  = extract_code(chain, POT0_MSB_POS);
            latch_next.w1  = extract_code(chain, POT1_MSB_POS);
            latch_next.sel = chain[SEL_POS];
            latch_next.upd = 1'b1;
        end
        // Registered so the stacked output changes in the same cycle as the wipers
        latch_next.stacked = latch_next.sel ? latch_next.w1 : latch_next.w0;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            latch_reg <= '{w0: WIPER_MIDSCALE, w1: WIPER_MIDSCALE,
                           stacked: WIPER_MIDSCALE, sel: SEL_RESET, upd: 1'b0};
        end else begin
            latch_reg <= latch_next;
        end
    end

    assign wiper_zero   = latch_reg.w0;
    assign wiper_one    = latch_reg.w1;
    assign stacked      = latch_reg.stacked;
    assign stack_select = latch_reg.sel;
    assign updated      = latch_reg.upd;

endmodule : wiper_latch

`default_nettype wire

// ==== test/wiper_loader_asserts.sv ====
// Port checker for the serial wiper loader
`timescale 1ns/1ps
`default_nettype none
module wiper_loader_asserts (
    // System clock and reset
    input wire logic                    clk,
    input wire logic                    nrst,
    // Serial select
    input wire logic                    port_select,
    // Latched state and status
    input wire wiper_loader_pkg::code_t wiper_terminal_zero,
    input wire wiper_loader_pkg::code_t wiper_terminal_one,
    input wire wiper_loader_pkg::code_t stacked_wiper_out,
    input wire logic                    stack_select,
    input wire logic                    wiper_update,
    input wire logic                    frame_short,
    input wire logic                    port_active
);
    import wiper_loader_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_STACK_MUX: assert property (stacked_wiper_out ==
        (stack_select ? wiper_terminal_one : wiper_terminal_zero)) else $error("stacked mismatch");
    AST_W0_HOLD: assert property ($changed(wiper_terminal_zero) |-> wiper_update)
        else $error("wiper zero moved");
    AST_W1_HOLD: assert property ($changed(wiper_terminal_one) |-> wiper_update)
        else $error("wiper one moved");
    AST_SEL_HOLD: assert property ($changed({stack_select, frame_short}) |-> wiper_update)
        else $error("select moved");
    AST_UPD_PULSE: assert property (wiper_update |=> !wiper_update)
        else $error("update too long");
    AST_UPD_IDLE: assert property (wiper_update |-> !port_active)
        else $error("update while active");
    AST_FALL_UPD: assert property ($fell(port_active) |-> ##[0:2] wiper_update)
        else $error("no update after deselect");
    AST_ACTIVE: assert property (port_select [*5] |-> port_active)
        else $error("port not active");
    AST_RESET_MID: assert property ($rose(nrst) |-> wiper_terminal_zero == WIPER_MIDSCALE
        && wiper_terminal_one == WIPER_MIDSCALE && !stack_select) else $error("not mid-scale");
    COV_UPD: cover property (wiper_update);
    COV_SHORT: cover property ($rose(frame_short));
    COV_STACK: cover property ($rose(stack_select));
endmodule : wiper_loader_asserts
`default_nettype wire

// ==== test/serial_ctrl_model.sv ====
// Controller model driving the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_model (
    // Serial port toward the loader
    output logic      sclk,
    output logic      port_select,
    output logic      serial_data_in,
    // Cascade return
    input  wire logic chain_data_out
);
    logic [16:0] rx;
    initial begin
        sclk = 1'b0;
        port_select = 1'b0;
        serial_data_in = 1'b0;
        rx = '0;
    end
    // Idle edges; data is toggled on every edge and port select is left as it is
    task automatic tick(input int n);
        repeat (n) begin
            serial_data_in = ~serial_data_in;
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
    endtask : tick
    // n bits from the top of w; fb loops the cascade back in
    task automatic frame(input logic [16:0] w, input int n, input logic fb);
        port_select = 1'b1;
        for (int i = 16; i > 16 - n; i--) begin
            #3 serial_data_in = fb ? chain_data_out : w[i];
            rx = {rx[15:0], chain_data_out};
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
        #3 port_select = 1'b0;
        serial_data_in = ~serial_data_in;
    endtask : frame
endmodule : serial_ctrl_model
`default_nettype wire

// ==== test/dual_wiper_serial_loader_tb_top.sv ====
// Self-checking bench for the serial wiper loader
`timescale 1ns/1ps
`default_nettype none
module dual_wiper_serial_loader_tb_top;
    import wiper_loader_pkg::*;
    logic        clk, nrst, sclk, port_select, serial_data_in, chain_data_out;
    code_t       w0, w1, st;
    logic        sel, upd, fshort, act;
    int          n_fail = 0;
    int          check_count = 0;
    logic [16:0] rows [3] = '{{1'b1, 8'hA5, 8'h3C}, {1'b0, 8'hFF, 8'h00}, {1'b1, 8'h01, 8'h80}};
    logic [16:0] last_word;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    serial_ctrl_model i_serial_ctrl_model (.sclk, .port_select, .serial_data_in, .chain_data_out);
    dual_wiper_serial_loader i_dual_wiper_serial_loader (.clk, .nrst, .sclk, .port_select,
        .serial_data_in, .chain_data_out, .wiper_terminal_zero(w0), .wiper_terminal_one(w1),
        .stacked_wiper_out(st), .stack_select(sel), .wiper_update(upd), .frame_short(fshort),
        .port_active(act));
    task automatic close_out();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk_code(input string what, input code_t e, input code_t g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk_code
    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_code(what, {7'h00, e}, {7'h00, g});
    endtask : chk_bit
    task automatic chk_word(input logic [16:0] w);
        chk_code("wiper zero", w[7:0], w0);
        chk_code("wiper one", w[15:8], w1);
        chk_bit("select", w[16], sel);
        chk_code("stacked", w[16] ? w[15:8] : w[7:0], st);
    endtask : chk_word
    // Extra edges keep the select low time between frames
    task automatic wait_upd();
        int k;
        for (k = 0; k < 40 && upd !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk_bit("update", 1'b1, upd);
        if (upd !== 1'b1) begin
            close_out();
        end else begin
            repeat (4) @(posedge clk);
        end
    endtask : wait_upd
    // Serial clock must tick in reset for the chain to clear
    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        fork
            i_serial_ctrl_model.tick(8);
            repeat (8) @(posedge clk);
        join
        nrst <= 1'b1;
        i_serial_ctrl_model.tick(4);
        @(posedge clk);
    endtask : do_reset
    initial begin
        nrst <= 1'b0;
        do_reset();
        // Chain comes out of reset holding the mid-scale image
        last_word = {1'b0, WIPER_MIDSCALE, WIPER_MIDSCALE};
        foreach (rows[r]) begin
            i_serial_ctrl_model.frame(rows[r], 17, 1'b0);
            wait_upd();
            chk_word(rows[r]);
            chk_code("out one", last_word[15:8], i_serial_ctrl_model.rx[15:8]);
            chk_code("out zero", last_word[7:0], i_serial_ctrl_model.rx[7:0]);
            chk_bit("out select", last_word[16], i_serial_ctrl_model.rx[16]);
            chk_bit("cascade idle", rows[r][16], chain_data_out);
            chk_bit("active", 1'b0, act);
            chk_bit("short", 1'b0, fshort);
            last_word = rows[r];
            $display("row %0d done", r);
        end
        i_serial_ctrl_model.tick(10);
        chk_word(rows[2]);
        i_serial_ctrl_model.frame('0, 17, 1'b1);
        wait_upd();
        chk_code("read one", rows[2][15:8], i_serial_ctrl_model.rx[15:8]);
        chk_code("read zero", rows[2][7:0], i_serial_ctrl_model.rx[7:0]);
        chk_bit("first out", rows[2][16], i_serial_ctrl_model.rx[16]);
        chk_word(rows[2]);
        $display("readback done");
        i_serial_ctrl_model.frame(17'h1FFFF, 5, 1'b0);
        wait_upd();
        chk_bit("short", 1'b1, fshort);
        i_serial_ctrl_model.frame(rows[0], 17, 1'b0);
        wait_upd();
        chk_word(rows[0]);
        chk_bit("short", 1'b0, fshort);
        $display("short frame done");
        do_reset();
        chk_word({1'b0, WIPER_MIDSCALE, WIPER_MIDSCALE});
        chk_bit("cascade reset", 1'b0, chain_data_out);
        $display("reset done");
        close_out();
    end
endmodule : dual_wiper_serial_loader_tb_top
bind dual_wiper_serial_loader wiper_loader_asserts i_wiper_loader_asserts (.clk, .nrst,
    .port_select, .wiper_terminal_zero, .wiper_terminal_one, .stacked_wiper_out,
    .stack_select, .wiper_update, .frame_short, .port_active);
`default_nettype wire
